// ### rtl/ocs_timer_top.sv
// output compare timer with module standby control, apb register slave
// assumes apb master keeps the request stable until pready; inputs are
// synchronous to pclk
//
// What this block does
// - counter register reads return current count
// - uncoupled write loads only addressed counter
// - coupled write loads both counters alike
// - any combination of four pins outputs
// - match drives pin low, high or toggles
// - pins hold initial level until match
// - counter clears on overflow or compare a
// - compare c and d steer pins a, b
// - internal timer still gives events, triggers
// - external_interrupt_zero_pin pin gpio, cutoff or interrupt
// - each pin selectable gpio or compare
// - standby bit four stops compare timer
// - timer range blocked while in standby
// - bit three idles serial unit; its range is refused in any case
// - bit five idles other timer; its range is refused in any case
// - unassigned standby bits read zero except bit six
// - compare a match stops count if selected
// - match and overflow raise interrupt request
`timescale 1ns/1ps
module ocs_timer_top
    import ocs_pkg::*;
#(
    parameter int CNT_W  = 16,
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [ADDR_W-1:0]          paddr,
    input  wire logic [DATA_W-1:0]          pwdata,
    output logic                            pready,
    output logic      [DATA_W-1:0]          prdata,
    output logic                            pslverr,
    // pins
    input  wire logic                       ext_external_interrupt_zero_pin,
    output logic      [NUM_CH*NUM_PIN-1:0]  compare_pin_out,
    output logic      [NUM_CH*NUM_PIN-1:0]  compare_pin_oe_n,
    // events
    output logic      [NUM_CH*NUM_PIN-1:0]  converter_trigger,
    output logic      [NUM_CH-1:0]          channel_irq,
    output logic                            ext_external_interrupt_zero_pin_irq,
    // standby levels
    output logic                            compare_timer_standby,
    output logic                            serial_unit_standby,
    output logic                            other_timer_standby
);

    // refuse widths the index decode and counter fields cannot serve
    if (ADDR_W < IDX_W + IDX_LSB || CNT_W != 16) begin : g_bad_width
        $error("ocs_timer_top: address or counter width not served");
    end

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0]                          standby;
    logic [NUM_CH-1:0]                   start;
    logic [NUM_CH-1:0]                   csel;
    logic                                sync;
    ocs_external_interrupt_zero_pin_mode_t                      external_interrupt_zero_pin_mode;
    logic                                ext_external_interrupt_zero_pin_q;
    ocs_chan_cfg_t                       cfg     [NUM_CH];
    logic [NUM_PIN-1:0][CNT_W-1:0]       gr      [NUM_CH];
    logic [FLAG_W-1:0]                   flags   [NUM_CH];
    logic [CNT_W-1:0]                    count   [NUM_CH];
    ocs_chan_evt_t                       evt     [NUM_CH];

    // decode wires
    logic [IDX_W-1:0]                    idx;
    logic [3:0]                          ofs;
    logic                                setup;
    logic                                wr;
    logic                                timer_blocked;
    logic                                ofs_ok;
    logic                                valid;
    logic [NUM_CH-1:0]                   ch_hit;
    logic [NUM_CH-1:0]                   run;
    logic [NUM_CH-1:0]                   load;
    logic [NUM_CH-1:0]                   wr_count;
    logic [NUM_CH-1:0]                   start_pulse;
    logic [NUM_CH-1:0]                   stop_evt;
    logic [NUM_CH-1:0]                   next_start;
    logic [NUM_CH*NUM_PIN-1:0]           next_oe_n;
    logic                                cutoff;
    logic [DATA_W-1:0]                   rd_word;

    function automatic logic in_range(input logic [IDX_W-1:0] i,
                                      input logic [IDX_W-1:0] lo,
                                      input logic [IDX_W-1:0] hi);
        in_range = (i >= lo) && (i <= hi);
    endfunction

    // sources come in as arguments so the continuous select follows each of them
    function automatic logic [DATA_W-1:0] chan_word(input ocs_chan_cfg_t                 cf,
                                                    input logic [FLAG_W-1:0]             fl,
                                                    input logic [CNT_W-1:0]              cn,
                                                    input logic [NUM_PIN-1:0][CNT_W-1:0] g,
                                                    input logic [3:0]                    o);
        chan_word = '0;
        unique case (o)
            OFS_CTRL:   chan_word[3:0] = {cf.count_source, cf.clear_on_a};
            OFS_PIN_EN: chan_word[3:0] = cf.pin_enable;
            OFS_ACTION: chan_word[7:0] = cf.action;
            OFS_INIT:   chan_word[3:0] = cf.init_level;
            OFS_REUSE:  chan_word[1:0] = cf.reuse;
            OFS_FLAGS:  chan_word[FLAG_W-1:0] = fl;
            OFS_COUNT:  chan_word[CNT_W-1:0] = cn;
            default:    chan_word[CNT_W-1:0] = (o >= OFS_GRA && o <= OFS_GRD) ?
                                               g[o[1:0]] : '0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // apb decode; a write lands only at the edge that completes the access
    assign idx    = paddr[IDX_LSB+:IDX_W];
    assign ofs    = idx[3:0];
    assign setup  = psel & ~penable;
    assign wr     = psel & penable & pready & pwrite & ~pslverr;
    assign ofs_ok = (ofs <= OFS_COUNT) || (ofs >= OFS_GRA && ofs <= OFS_GRD);
    assign timer_blocked = standby[SB_TIMER] & in_range(idx, IDX_TIMER_LO, IDX_TIMER_HI);
    // standby index sits outside every blocked range
    assign valid  = (idx == IDX_STANDBY) || (idx == IDX_PIN_FUNC) ||
                    (idx == IDX_START) || (idx == IDX_MODE) || (|ch_hit && ofs_ok);

    // read selection; unassigned standby bits but bit six are zero by the write mask
    assign rd_word = !valid || timer_blocked ? '0 :
                     idx == IDX_STANDBY  ? {24'h000000, standby} :
                     idx == IDX_PIN_FUNC ? {30'h00000000, external_interrupt_zero_pin_mode} :
                     idx == IDX_START    ? {24'h000000, START_FILL |
                                            {4'h0, csel, start}} :
                     idx == IDX_MODE     ? {24'h000000, MODE_FILL | {7'h00, sync}} :
                     ch_hit[1]           ? chan_word(cfg[1], flags[1], count[1], gr[1], ofs) :
                                           chan_word(cfg[0], flags[0], count[0], gr[0], ofs);

    // no wait state: the read word is taken in setup so prdata is a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= setup;
            pslverr <= setup & (~valid | timer_blocked);
            prdata  <= setup ? rd_word : prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // standby, start, mode and external_interrupt_zero_pin function registers
    assign stop_evt    = {evt[1].match[0] & ~csel[1], evt[0].match[0] & ~csel[0]};
    assign next_start  = ((wr && idx == IDX_START) ? pwdata[NUM_CH-1:0] : start) & ~stop_evt;
    assign start_pulse = next_start & ~start;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standby    <= STANDBY_RESET;
            start      <= '0;
            csel       <= '1;
            sync       <= 1'b0;
            external_interrupt_zero_pin_mode  <= OCS_EXTERNAL_INTERRUPT_ZERO_PIN_GPIO;
        end else begin
            start <= next_start;
            if (wr && idx == IDX_STANDBY) begin
                standby <= pwdata[7:0] & STANDBY_WMASK;
            end
            if (wr && idx == IDX_START) begin
                csel <= pwdata[START_CSEL+:NUM_CH];
            end
            if (wr && idx == IDX_MODE) begin
                sync <= pwdata[0];
            end
            if (wr && idx == IDX_PIN_FUNC && pwdata[1:0] != 2'b11) begin
                external_interrupt_zero_pin_mode <= ocs_external_interrupt_zero_pin_mode_t'(pwdata[1:0]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // channels; a coupled write to either counter loads both
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        assign ch_hit[c]   = idx[IDX_W-1:4] == IDX_CH0[IDX_W-1:4] + 6'(c);
        assign wr_count[c] = wr & ch_hit[c] & (ofs == OFS_COUNT);
        assign run[c]      = start[c] & ~standby[SB_TIMER];
        assign load[c]     = wr_count[c] | (sync & wr_count[1-c]);

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cfg[c]   <= '0;
                gr[c]    <= '{default: {CNT_W{1'b1}}};
                flags[c] <= '0;
            end else begin
                // set wins over a software clear in the same cycle
                flags[c] <= (flags[c] & ((wr && ch_hit[c] && ofs == OFS_FLAGS) ?
                            pwdata[FLAG_W-1:0] : {FLAG_W{1'b1}})) | evt[c];
                if (wr && ch_hit[c]) begin
                    unique case (ofs)
                        OFS_CTRL:   {cfg[c].count_source, cfg[c].clear_on_a} <= pwdata[3:0];
                        OFS_PIN_EN: cfg[c].pin_enable <= pwdata[3:0];
                        OFS_ACTION: cfg[c].action     <= pwdata[7:0];
                        OFS_INIT:   cfg[c].init_level <= pwdata[3:0];
                        OFS_REUSE:  cfg[c].reuse      <= pwdata[1:0];
                        default: begin
                            if (ofs >= OFS_GRA) begin
                                gr[c][ofs[1:0]] <= pwdata[CNT_W-1:0];
                            end
                        end
                    endcase
                end
            end
        end

        ocs_channel #(.CNT_W(CNT_W)) u_channel (
            .pclk       (pclk),
            .presetn    (presetn),
            .run        (run[c]),
            .clear_on_a (cfg[c].clear_on_a),
            .load       (load[c]),
            .load_value (pwdata[CNT_W-1:0]),
            .compare    (gr[c]),
            .count      (count[c]),
            .evt        (evt[c])
        );

        ocs_pin_unit u_pins (
            .pclk        (pclk),
            .presetn     (presetn),
            .start_pulse (start_pulse[c]),
            .match       (evt[c].match),
            .action      (cfg[c].action),
            .init_level  (cfg[c].init_level),
            .reuse       (cfg[c].reuse),
            .level       (compare_pin_out[c*NUM_PIN+:NUM_PIN])
        );

        // pins not enabled stay with general i/o; cutoff releases them all
        assign next_oe_n[c*NUM_PIN+:NUM_PIN] = ~(cfg[c].pin_enable & {NUM_PIN{~cutoff}});
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin enables, triggers and interrupt pulses, all registered
    assign cutoff = (external_interrupt_zero_pin_mode == OCS_EXTERNAL_INTERRUPT_ZERO_PIN_CUTOFF) & ~ext_external_interrupt_zero_pin;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_pin_oe_n  <= '1;
            converter_trigger <= '0;
            channel_irq       <= '0;
            ext_external_interrupt_zero_pin_q        <= 1'b1;
            ext_external_interrupt_zero_pin_irq      <= 1'b0;
        end else begin
            compare_pin_oe_n  <= next_oe_n;
            converter_trigger <= {evt[1].match, evt[0].match};
            channel_irq       <= {|evt[1], |evt[0]};
            ext_external_interrupt_zero_pin_q        <= ext_external_interrupt_zero_pin;
            ext_external_interrupt_zero_pin_irq      <= (external_interrupt_zero_pin_mode == OCS_EXTERNAL_INTERRUPT_ZERO_PIN_IRQ) & ext_external_interrupt_zero_pin_q & ~ext_external_interrupt_zero_pin;
        end
    end

    // standby levels straight from the register flops for the siblings
    assign compare_timer_standby = standby[SB_TIMER];
    assign serial_unit_standby   = standby[SB_SERIAL];
    assign other_timer_standby   = standby[SB_OTHER];

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_read(logic [IDX_W-1:0] i);
        setup && !pwrite && idx == i && !standby[SB_TIMER];
    endsequence

    timer_block_a: assert property (setup && timer_blocked |=> pslverr && prdata == '0)
        else $error("blocked timer access was not refused");

    count_read_a: assert property (s_read(IDX_CH0 + 10'h006)
        |=> prdata[CNT_W-1:0] == $past(count[0]))
        else $error("counter read returned wrong value");

    sync_load_a: assert property (wr && sync && idx == IDX_CH0 + 10'h006
        |=> count[1] == $past(pwdata[CNT_W-1:0]))
        else $error("coupled write did not load second counter");

    indep_load_a: assert property (wr && !sync && idx == IDX_CH0 + 10'h006 && !run[1]
        |=> count[1] == $past(count[1]))
        else $error("independent write disturbed other counter");

    match_stop_a: assert property (evt[0].match[0] && !csel[0] |=> !start[0] ##1 !evt[0].match[0])
        else $error("counter kept running after compare a match");

    clear_on_a_a: assert property (evt[0].match[0] && cfg[0].clear_on_a && !load[0]
        |=> count[0] == '0)
        else $error("counter not cleared on compare a match");

    standby_read_a: assert property (setup && !pwrite && idx == IDX_STANDBY
        |=> prdata[2:0] == 3'h0 && prdata[7] == 1'b0 && !pslverr)
        else $error("unassigned standby bits read nonzero");

    irq_event_a: assert property (|evt[0] |=> channel_irq[0] && flags[0] != '0)
        else $error("match or overflow raised no interrupt request");

    cutoff_pins_a: assert property (cutoff |=> compare_pin_oe_n == '1)
        else $error("pins still driven during forced cutoff");

    trigger_a: assert property (evt[0].match[1] |=> converter_trigger[1])
        else $error("compare match gave no converter trigger");

endmodule

// ### include/ocs_pkg.sv
// constants, field layouts and carrier types of the output compare timer
// assumes an apb slave that sees register indices as paddr word addresses
package ocs_pkg;

    // register index width and index position inside the byte address
    localparam int IDX_W    = 10;
    localparam int IDX_LSB  = 2;
    localparam int DATA_W   = 32;
    localparam int NUM_CH   = 2;
    localparam int NUM_PIN  = 4;
    localparam int FLAG_W   = 5;

    ////////////////////////////////////////////////////////////////////////////
    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_STANDBY   = 10'h008;
    localparam logic [IDX_W-1:0] IDX_TIMER_LO  = 10'h135;
    localparam logic [IDX_W-1:0] IDX_TIMER_HI  = 10'h15F;
    localparam logic [IDX_W-1:0] IDX_SERIAL_LO = 10'h193;
    localparam logic [IDX_W-1:0] IDX_SERIAL_HI = 10'h19D;
    localparam logic [IDX_W-1:0] IDX_OTHER_LO  = 10'h120;
    localparam logic [IDX_W-1:0] IDX_OTHER_HI  = 10'h133;
    localparam logic [IDX_W-1:0] IDX_PIN_FUNC  = 10'h135;
    localparam logic [IDX_W-1:0] IDX_START     = 10'h137;
    localparam logic [IDX_W-1:0] IDX_MODE      = 10'h138;
    localparam logic [IDX_W-1:0] IDX_CH0       = 10'h140;

    // offsets inside one channel block of sixteen indices
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_PIN_EN = 4'h1;
    localparam logic [3:0] OFS_ACTION = 4'h2;
    localparam logic [3:0] OFS_INIT   = 4'h3;
    localparam logic [3:0] OFS_REUSE  = 4'h4;
    localparam logic [3:0] OFS_FLAGS  = 4'h5;
    localparam logic [3:0] OFS_COUNT  = 4'h6;
    localparam logic [3:0] OFS_GRA    = 4'h8;
    localparam logic [3:0] OFS_GRD    = 4'hB;

    ////////////////////////////////////////////////////////////////////////////
    // standby register layout
    localparam int         SB_SERIAL     = 3;
    localparam int         SB_TIMER      = 4;
    localparam int         SB_OTHER      = 5;
    localparam logic [7:0] STANDBY_WMASK = 8'h78;
    localparam logic [7:0] STANDBY_RESET = 8'h00;

    // start and mode register layout, unassigned bits read as one except mode bits 7 to 4
    localparam int         START_CSEL = 2;
    localparam logic [7:0] START_FILL = 8'hF0;
    localparam logic [7:0] MODE_FILL  = 8'h0E;

    // compare match actions, two bits per pin
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_LOW    = 2'h1;
    localparam logic [1:0] ACT_HIGH   = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    typedef enum logic [1:0] {
        OCS_EXTERNAL_INTERRUPT_ZERO_PIN_GPIO   = 2'b00,
        OCS_EXTERNAL_INTERRUPT_ZERO_PIN_CUTOFF = 2'b01,
        OCS_EXTERNAL_INTERRUPT_ZERO_PIN_IRQ    = 2'b10
    } ocs_external_interrupt_zero_pin_mode_t;

    // per channel setup written by software
    typedef struct packed {
        logic [1:0] reuse;
        logic [3:0] init_level;
        logic [7:0] action;
        logic [3:0] pin_enable;
        logic [2:0] count_source;
        logic       clear_on_a;
    } ocs_chan_cfg_t;

    // per channel events, overflow on top to match the flag layout
    typedef struct packed {
        logic       overflow;
        logic [3:0] match;
    } ocs_chan_evt_t;

endpackage

// ### rtl/ocs_channel.sv
// one channel counter with its four compare values
// assumes run, load and compare values are synchronous to pclk
`timescale 1ns/1ps
module ocs_channel
    import ocs_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // control
    input  wire logic                        run,
    input  wire logic                        clear_on_a,
    input  wire logic                        load,
    input  wire logic [CNT_W-1:0]            load_value,
    input  wire logic [NUM_PIN-1:0][CNT_W-1:0] compare,
    // state
    output logic      [CNT_W-1:0]            count,
    output ocs_chan_evt_t                    evt
);

    // refuse counter widths that the bus word cannot carry
    if (CNT_W < 8 || CNT_W > DATA_W) begin : g_bad_width
        $error("ocs_channel: counter width out of range");
    end

    logic [CNT_W-1:0] next_count;

    ////////////////////////////////////////////////////////////////////////////
    // events only fire while counting, so a stopped channel stays silent
    for (genvar j = 0; j < NUM_PIN; j++) begin : g_cmp
        assign evt.match[j] = run & (count == compare[j]);
    end
    assign evt.overflow = run & (count == {CNT_W{1'b1}});

    // software load beats counting; clear on a match of compare a or wrap
    assign next_count = load                         ? load_value :
                        !run                         ? count :
                        (clear_on_a && evt.match[0]) ? {CNT_W{1'b0}} :
                        count + {{(CNT_W-1){1'b0}}, 1'b1};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wrap_to_zero_a: assert property (evt.overflow && !load && !(clear_on_a && evt.match[0])
        |=> count == {CNT_W{1'b0}})
        else $error("counter did not wrap to zero on overflow");

    frozen_stop_a: assert property (!run && !load |=> $stable(count))
        else $error("counter moved while stopped");

endmodule

// ### rtl/ocs_pin_unit.sv
// four compare output levels of one channel
// assumes match events come straight from the channel compare
`timescale 1ns/1ps
module ocs_pin_unit
    import ocs_pkg::*;
(
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // control
    input  wire logic               start_pulse,
    input  wire logic [NUM_PIN-1:0] match,
    input  wire logic [7:0]         action,
    input  wire logic [3:0]         init_level,
    input  wire logic [1:0]         reuse,
    // levels
    output logic      [NUM_PIN-1:0] level
);

    logic [NUM_PIN-1:0] hit;
    logic [NUM_PIN-1:0] next_level;

    function automatic logic apply(input logic [1:0] act, input logic cur);
        unique case (act)
            ACT_LOW:    apply = 1'b0;
            ACT_HIGH:   apply = 1'b1;
            ACT_TOGGLE: apply = ~cur;
            ACT_NONE:   apply = cur;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // compare c and d may steer pins a and b and then leave their own pins
    assign hit[0] = match[0] | (reuse[0] & match[2]);
    assign hit[1] = match[1] | (reuse[1] & match[3]);
    assign hit[2] = match[2] & ~reuse[0];
    assign hit[3] = match[3] & ~reuse[1];

    for (genvar j = 0; j < NUM_PIN; j++) begin : g_pin
        assign next_level[j] = start_pulse ? init_level[j] :
                               hit[j]      ? apply(action[2*j+:2], level[j]) :
                               level[j];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= '0;
        end else begin
            level <= next_level;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    toggle_on_hit_a: assert property (!start_pulse && hit[0]
        && action[1:0] == ACT_TOGGLE |=> level[0] == !$past(level[0]))
        else $error("pin a did not toggle on match");

    init_level_a: assert property (start_pulse ##1 !hit[1] [*2]
        |-> level[1] == $past(init_level[1], 2))
        else $error("pin b lost its initial level before a match");

endmodule

// ### tb/ocs_timer_top_tb.sv
// self-checking bench for the output compare timer with standby control
// assumes apb slave with no wait state and indices as word addresses
`timescale 1ns/1ps
module ocs_timer_top_tb
    import ocs_pkg::*;
;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, ext_external_interrupt_zero_pin = 1'b1, pready, pslverr, rerr, int_irq;
    logic        sb_t, sb_s, sb_o;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat, sb, v0;
    logic [7:0]  pin_out, oe_n, trig;
    logic [1:0]  irq;
    int          err_count = 0, tests_run = 0;

    always #20 pclk = ~pclk;

    ocs_timer_top i_ocs_timer_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .ext_external_interrupt_zero_pin(ext_external_interrupt_zero_pin),
        .compare_pin_out(pin_out), .compare_pin_oe_n(oe_n), .converter_trigger(trig),
        .channel_irq(irq), .ext_external_interrupt_zero_pin_irq(int_irq), .compare_timer_standby(sb_t),
        .serial_unit_standby(sb_s), .other_timer_standby(sb_o));

    ////////////////////////////////////////////////////////////////////////////
    // compare, bus cycle and expectation helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // holds the request until pready is seen high at a rising edge, then idles a cycle
    task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {i, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic [9:0] ci(input int c, input logic [3:0] o);
        return IDX_CH0 + 10'(c * 16) + 10'(o);
    endfunction

    function automatic logic [31:0] ex_start(input logic [1:0] cs, input logic [1:0] st);
        return {24'h0, START_FILL | {4'h0, cs, st}};
    endfunction

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // watchdog, far beyond the two hundred or so cycles the tests need
    initial begin
        #(40 * 20000);
        err_count++;
        conclude;
    end

    initial begin
        void'($urandom(32'h90d284cd));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, IDX_STANDBY, 32'h0); chk(rdat, {24'h0, STANDBY_RESET});
        apb(1'b0, IDX_START, 32'h0); chk(rdat, ex_start(2'b11, 2'b00));
        apb(1'b0, IDX_MODE, 32'h0); chk(rdat, {24'h0, MODE_FILL});
        $display("test reset done");
        // first pass sets every bit but the reserved one; timer is stopped
        for (int k = 0; k < 6; k++) begin
            sb = ((k == 0) ? 32'hFF : $urandom) & 32'hFFFFFFBF;
            apb(1'b1, IDX_STANDBY, sb);
            apb(1'b0, IDX_STANDBY, 32'h0); chk(rdat, sb & 32'h78);
            chk({29'h0, sb_s, sb_t, sb_o}, {29'h0, sb[3], sb[4], sb[5]});
            apb(1'b0, k[0] ? IDX_TIMER_LO : IDX_START, 32'h0);
            chk({31'h0, rerr}, {31'h0, sb[4]});
        end
        apb(1'b1, IDX_STANDBY, 32'h0);
        apb(1'b0, 10'h3FF, 32'h0); chk({31'h0, rerr}, 32'h1);
        $display("test standby done");
        v0 = $urandom & 32'hFFFF;
        apb(1'b1, ci(0, OFS_COUNT), v0);
        apb(1'b1, ci(1, OFS_COUNT), ~v0 & 32'hFFFF);
        apb(1'b0, ci(0, OFS_COUNT), 32'h0); chk(rdat, v0);
        apb(1'b0, ci(1, OFS_COUNT), 32'h0); chk(rdat, ~v0 & 32'hFFFF);
        apb(1'b1, IDX_MODE, 32'h1);
        apb(1'b1, ci(0, OFS_COUNT), v0 ^ 32'h5A5A);
        apb(1'b0, ci(1, OFS_COUNT), 32'h0); chk(rdat, v0 ^ 32'h5A5A);
        apb(1'b1, IDX_MODE, 32'h0);
        $display("test counter done");
        // pin a goes high at match 40, pin b low at match 20, stop on a
        apb(1'b1, ci(0, OFS_COUNT), 32'h0);
        apb(1'b1, ci(0, OFS_CTRL), 32'h1);
        apb(1'b1, ci(0, OFS_PIN_EN), 32'h3);
        apb(1'b1, ci(0, OFS_ACTION), 32'h6);
        apb(1'b1, ci(0, OFS_INIT), 32'h2);
        apb(1'b1, ci(0, OFS_GRA), 32'd40);
        apb(1'b1, ci(0, OFS_GRA + 4'h1), 32'd20);
        apb(1'b1, IDX_START, 32'h9);
        repeat (4) @(posedge pclk);
        chk({30'h0, pin_out[1:0]}, 32'h2);
        chk({24'h0, oe_n}, 32'hFC);
        // match b at count 20, pulses seen two edges later
        repeat (17) @(posedge pclk);
        chk({22'h0, irq, trig}, {22'h0, 2'b01, 8'h02});
        repeat (33) @(posedge pclk);
        chk({30'h0, pin_out[1:0]}, 32'h1);
        apb(1'b0, IDX_START, 32'h0); chk(rdat, ex_start(2'b10, 2'b00));
        $display("test compare done");
        // low external_interrupt_zero_pin releases all pins in cutoff, falls raise a pulse in irq mode
        apb(1'b1, IDX_PIN_FUNC, 32'h1);
        ext_external_interrupt_zero_pin <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({24'h0, oe_n}, 32'hFF);
        ext_external_interrupt_zero_pin <= 1'b1;
        apb(1'b1, IDX_PIN_FUNC, 32'h2);
        ext_external_interrupt_zero_pin <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({31'h0, int_irq}, 32'h1);
        ext_external_interrupt_zero_pin <= 1'b1;
        $display("test external_interrupt_zero_pin done");
        conclude;
    end
endmodule
